/* bench/adc_config_register_bank_tb.sv */
// testbench for the configuration bank, host model on the byte link
// assumes the package constants describe the register map
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("Error at %0t: got %h want %h", $time, g, e); \
  end \
end
module adc_config_register_bank_tb;
  import regbank_pkg::*;
  // ****
  // signals and instances
  // ****
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic starting_up_i = 1'b0;
  logic vref_below_limit_i = 1'b0;
  logic converting_i = 1'b0;
  logic clk_en = 1'b1;
  logic frame_active, rx_valid, tx_ready, tx_valid, busy, restart, mon_en;
  logic [7:0] rx_byte, tx_byte, exp;
  logic [15:0] ofs_trim, scl_trim;
  logic [143:0] cfg;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int restart_cnt = 0;

  always #2 clk_i = ~clk_i;

  adc_config_register_bank dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en), .frame_active_i(frame_active), .rx_valid_i(rx_valid),
    .rx_byte_i(rx_byte), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid),
    .tx_byte_o(tx_byte), .busy_o(busy), .starting_up_i(starting_up_i),
    .vref_below_limit_i(vref_below_limit_i), .converting_i(converting_i),
    .restart_conv_o(restart), .vref_monitor_enable_o(mon_en),
    .offset_trim_value_o(ofs_trim), .scale_trim_value_o(scl_trim),
    .config_bytes_o(cfg));

  host_model host_u (.clk_i(clk_i), .frame_active_o(frame_active),
    .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_ready_o(tx_ready),
    .tx_valid_i(tx_valid), .tx_byte_i(tx_byte));

  always @(posedge clk_i) begin
    if (restart === 1'b1) restart_cnt++;
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end

  // ****
  // helpers and scenarios
  // ****
  task automatic wr1(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] d[$];
    d.push_back(v);
    host_u.write_regs(a, d);
  endtask : wr1

  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    host_u.read_regs(a, 1);
    `CHK(host_u.got[0], e)
  endtask : chk_reg

  task automatic t_defaults;
    host_u.read_regs(5'h00, 20);
    `CHK(host_u.got[0][2:0], MODEL_CODE_DEFAULT)
    for (int i = 1; i < 20; i++) begin
      exp = (i < 18) ? RESET_VALUES[8*i +: 8] : 8'h00;
      `CHK(host_u.got[i], exp)
    end
  endtask : t_defaults

  task automatic t_block;
    logic [7:0] d[$];
    d = {8'h5A, 8'h12, 8'h34, 8'h77, 8'h56, 8'h78, 8'h9A, 8'h0C, 8'hEE,
         8'hDD};
    host_u.write_regs(5'h0A, d);
    `CHK(busy, 1'b0)
    `CHK(ofs_trim, 16'h3412)
    `CHK(scl_trim, 16'h7856)
    `CHK(cfg[8*16 +: 8], 8'h9A)
    host_u.ready_delay = 3;
    host_u.read_regs(5'h0A, 8);
    host_u.ready_delay = 0;
    for (int i = 0; i < 8; i++) begin
      exp = d[i] & WRITE_MASKS[8*(i+10) +: 8];
      `CHK(host_u.got[i], exp)
    end
  endtask : t_block

  task automatic t_status;
    logic [7:0] d[$];
    wr1(5'h01, 8'hFF);
    chk_reg(5'h01, 8'h80);
    d = {8'hFF, 8'h7F};
    host_u.write_regs(5'h00, d);
    host_u.read_regs(5'h00, 2);
    `CHK(host_u.got[0][2:0], MODEL_CODE_DEFAULT)
    `CHK(host_u.got[1], 8'h00)
    starting_up_i = 1'b1;
    vref_below_limit_i = 1'b1;
    chk_reg(5'h01, 8'h40);
    wr1(5'h05, 8'h50);
    `CHK(mon_en, 1'b1)
    chk_reg(5'h01, 8'h41);
    vref_below_limit_i = 1'b0;
    chk_reg(5'h01, 8'h40);
    wr1(5'h05, 8'h10);
    starting_up_i = 1'b0;
  endtask : t_status

  task automatic t_restart;
    logic [7:0] d[$];
    int base;
    base = restart_cnt;
    converting_i = 1'b1;
    wr1(5'h02, 8'h23);
    `CHK(restart_cnt, base + 1)
    wr1(5'h08, 8'h01);
    `CHK(restart_cnt, base + 1)
    wr1(5'h03, 8'h00);
    `CHK(restart_cnt, base + 2)
    converting_i = 1'b0;
    wr1(5'h03, 8'h01);
    `CHK(restart_cnt, base + 2)
    d = {8'h65, 8'h00, 8'hAA};
    host_u.send(d);
    host_u.finish_frame();
    chk_reg(5'h05, 8'h10);
    chk_reg(5'h02, 8'h23);
  endtask : t_restart

  task automatic t_freeze;
    clk_en = 1'b0;
    wr1(5'h06, 8'h05);
    `CHK(busy, 1'b0)
    clk_en = 1'b1;
    chk_reg(5'h06, 8'h00);
  endtask : t_freeze

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_defaults();
    t_freeze();
    t_block();
    t_status();
    t_restart();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_defaults();
    test_done();
  end
endmodule : adc_config_register_bank_tb
`undef CHK
`default_nettype wire

/* bench/host_model.sv */
// host model: issues register commands over the byte link
// assumes the bank takes bytes and tx handshakes on the rising edge
`timescale 1ns/1ps
`default_nettype none
module host_model
  import regbank_pkg::*;
(
  // clock
  input wire logic clk_i,
  // byte link
  output logic frame_active_o,
  output logic rx_valid_o,
  output logic [regbank_pkg::DATA_W-1:0] rx_byte_o,
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [regbank_pkg::DATA_W-1:0] tx_byte_i
);
  // ****
  // command tasks
  // ****
  logic [7:0] got[$];
  int ready_delay = 0;

  initial begin
    frame_active_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    tx_ready_o = 1'b0;
  end

  // bytes back to back, strobe held high between them
  task automatic send(input logic [7:0] b[$]);
    @(negedge clk_i);
    frame_active_o = 1'b1;
    foreach (b[i]) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_byte_o = b[i];
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
  endtask : send

  task automatic finish_frame;
    @(negedge clk_i);
    frame_active_o = 1'b0;
    rx_byte_o = ~rx_byte_o;
  endtask : finish_frame

  task automatic write_regs(input logic [4:0] a, input logic [7:0] d[$]);
    logic [7:0] b[$];
    b = d;
    b.push_front({3'h0, 5'(d.size() - 1)});
    b.push_front({REGISTER_WRITE_CMD, a});
    send(b);
    finish_frame();
  endtask : write_regs

  task automatic read_regs(input logic [4:0] a, input int n);
    logic [7:0] b[$];
    int w;
    b.push_back({REGISTER_READ_CMD, a});
    b.push_back({3'h0, 5'(n - 1)});
    send(b);
    got.delete();
    repeat (n) begin
      repeat (ready_delay) @(negedge clk_i);
      @(negedge clk_i);
      tx_ready_o = 1'b1;
      w = 0;
      @(posedge clk_i);
      while (tx_valid_i !== 1'b1 && w < 20) begin
        w++;
        @(posedge clk_i);
      end
      got.push_back(w < 20 ? tx_byte_i : 8'hXX);
      @(negedge clk_i);
      tx_ready_o = 1'b0;
    end
    finish_frame();
  endtask : read_regs
endmodule : host_model
`default_nettype wire

/* include/regbank_pkg.sv */
// register map constants for the converter configuration bank
// assumes one 250 MHz clock and a serial command engine outside the bank
package regbank_pkg;
  localparam int unsigned REG_COUNT = 18;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CLK_MHZ = 250;

  // register offsets
  localparam logic [4:0] PART_CODE_REG_ADDR = 5'h00;
  localparam logic [4:0] FLAG_REPORT_ADDR = 5'h01;
  localparam logic [4:0] INPUT_SELECTOR_ADDR = 5'h02;
  localparam logic [4:0] AMP_GAIN_CFG_ADDR = 5'h03;
  localparam logic [4:0] CONV_SPEED_CFG_ADDR = 5'h04;
  localparam logic [4:0] VSOURCE_SELECT_ADDR = 5'h05;
  localparam logic [4:0] EXCITATION_LEVEL_ADDR = 5'h06;
  localparam logic [4:0] EXCITATION_ROUTING_ADDR = 5'h07;
  localparam logic [4:0] MIDSUPPLY_BIAS_ADDR = 5'h08;
  localparam logic [4:0] MONITOR_TRIM_CFG_ADDR = 5'h09;
  localparam logic [4:0] SPARE_0A_ADDR = 5'h0A;
  localparam logic [4:0] OFFSET_TRIM_LOW_ADDR = 5'h0B;
  localparam logic [4:0] OFFSET_TRIM_HIGH_ADDR = 5'h0C;
  localparam logic [4:0] SPARE_0D_ADDR = 5'h0D;
  localparam logic [4:0] SCALE_TRIM_LOW_ADDR = 5'h0E;
  localparam logic [4:0] SCALE_TRIM_HIGH_ADDR = 5'h0F;
  localparam logic [4:0] LAST_ADDR = 5'h11;

  // default values, one per address
  localparam logic [8*18-1:0] RESET_VALUES = {
    8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
    8'h00, 8'hFF, 8'h00, 8'h10, 8'h14, 8'h00, 8'h01, 8'h80, 8'h00};

  // writable-bit masks; spares and read-only bytes hold zero
  localparam logic [8*18-1:0] WRITE_MASKS = {
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};

  // bytes with any bit set here restart a running conversion when written
  localparam logic [8*18-1:0] RESTART_MASKS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hE0,
    8'h00, 8'hFF, 8'h0F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};

  // status and control field positions
  localparam int unsigned POWERUP_FLAG_BIT = 7;
  localparam int unsigned STARTUP_BIT = 6;
  localparam int unsigned LOW_VREF_FLAG_BIT = 0;
  localparam int unsigned VREF_MONITOR_ENABLE_BIT = 6;
  localparam int unsigned MODEL_CODE_W = 3;

  // command opcodes in the top three bits of the first byte
  localparam logic [2:0] REGISTER_READ_CMD = 3'h1;
  localparam logic [2:0] REGISTER_WRITE_CMD = 3'h2;

  // model code: arbitrary neutral value
  localparam logic [2:0] MODEL_CODE_DEFAULT = 3'h3;

  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_COUNT,
    CMD_READ,
    CMD_WRITE
  } cmd_state_t;
endpackage : regbank_pkg

/* src/adc_config_register_bank.sv */
// configuration and status bank reached by serial register commands
// assumes a serial engine hands over whole bytes, one strobe per byte,
// and frames each command with a select level
// How it works
// - eighteen byte registers at addresses zero through seventeen
// - only the read and write commands reach the bank
// - every register takes its default on reset
// - one write command fills consecutive registers as a block
// - each written byte takes effect as soon as it arrives
// - any write to a byte holding restart bits abandons a running conversion and starts anew
// - address zero is read-only and carries the model code low bits
// - power-up flag in status bit seven resets to one
// - power-up flag stays set until host writes status with bit seven zero
// - status bit six reads one while starting up
// - status bit zero reads one while reference is low and its monitor enable bit is set
// - reference monitor runs only while its enable bit is set
// - channel, gain, rate, routing, reference and system bits restart
// - read command: 001 plus address, then 000 plus count minus one
// - write command: 010 plus address, count minus one, data bytes
// - reads past the end give zeros, writes past it are dropped
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank
  import regbank_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // serial byte link
  input wire logic frame_active_i,
  input wire logic rx_valid_i,
  input wire logic [regbank_pkg::DATA_W-1:0] rx_byte_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [regbank_pkg::DATA_W-1:0] tx_byte_o,
  output logic busy_o,
  // device state in
  input wire logic starting_up_i,
  input wire logic vref_below_limit_i,
  input wire logic converting_i,
  // configuration out
  output logic restart_conv_o,
  output logic vref_monitor_enable_o,
  output logic [15:0] offset_trim_value_o,
  output logic [15:0] scale_trim_value_o,
  output logic [8*18-1:0] config_bytes_o
);
  import regbank_pkg::*;

  // ************
  // command engine
  // ************
  cmd_state_t state_q, state_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_W-1:0] left_q, left_d;
  logic is_read_q, is_read_d;
  logic wrapped_q, wrapped_d;
  logic powerup_flag_q, low_vref_flag_q;
  logic tx_valid_q;
  logic rd_pending_q;
  logic restart_q;
  logic [8*18-1:0] regs;
  logic [DATA_W-1:0] store_rd;

  wire rx_take = clk_en_i && rx_valid_i && frame_active_i;
  wire [2:0] opcode = rx_byte_i[7:5];
  wire cmd_read = (opcode == REGISTER_READ_CMD);
  wire cmd_write = (opcode == REGISTER_WRITE_CMD);
  wire in_map = (addr_q <= LAST_ADDR) && !wrapped_q;
  wire data_write = (state_q == CMD_WRITE) && rx_take && in_map;
  wire tx_fire = tx_valid_q && tx_ready_i;
  wire [7:0] restart_msk = RESTART_MASKS[addr_q*DATA_W +: DATA_W];
  wire restart_hit = data_write && (restart_msk != 8'h00);
  wire status_write = data_write && (addr_q == FLAG_REPORT_ADDR);

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    left_d = left_q;
    is_read_d = is_read_q;
    wrapped_d = wrapped_q;
    case (state_q)
      CMD_IDLE: begin
        if (rx_take && (cmd_read || cmd_write)) begin
          state_d = CMD_COUNT;
          addr_d = rx_byte_i[ADDR_W-1:0];
          is_read_d = cmd_read;
          wrapped_d = 1'b0;
        end
      end
      CMD_COUNT: begin
        if (rx_take) begin
          left_d = rx_byte_i[ADDR_W-1:0];
          state_d = is_read_q ? CMD_READ : CMD_WRITE;
        end
      end
      CMD_READ: begin
        if (tx_fire) begin
          addr_d = addr_q + 5'h01;
          if (addr_q == {ADDR_W{1'b1}}) begin
            wrapped_d = 1'b1;
          end
          left_d = left_q - 5'h01;
          if (left_q == 5'h00) begin
            state_d = CMD_IDLE;
          end
        end
      end
      CMD_WRITE: begin
        if (rx_take) begin
          addr_d = addr_q + 5'h01;
          if (addr_q == {ADDR_W{1'b1}}) begin
            wrapped_d = 1'b1;
          end
          left_d = left_q - 5'h01;
          if (left_q == 5'h00) begin
            state_d = CMD_IDLE;
          end
        end
      end
      default: begin
        state_d = CMD_IDLE;
      end
    endcase
    if (!frame_active_i) begin
      state_d = CMD_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= CMD_IDLE;
      addr_q <= 5'h00;
      left_q <= 5'h00;
      is_read_q <= 1'b0;
      wrapped_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      addr_q <= addr_d;
      left_q <= left_d;
      is_read_q <= is_read_d;
      wrapped_q <= wrapped_d;
    end
  end

  // ************
  // byte store
  // ************
  reg_store u_store (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .wr_en_i(data_write),
    .wr_addr_i(addr_q),
    .wr_data_i(rx_byte_i),
    .rd_addr_i(addr_q),
    .rd_data_o(store_rd),
    .all_regs_o(regs)
  );

  // ************
  // read return
  // ************
  wire want_byte = (state_q == CMD_READ) && !tx_valid_q && !rd_pending_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_valid_q <= 1'b0;
      rd_pending_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!frame_active_i) begin
        tx_valid_q <= 1'b0;
        rd_pending_q <= 1'b0;
      end else begin
        rd_pending_q <= want_byte;
        if (rd_pending_q) begin
          tx_valid_q <= 1'b1;
        end else if (tx_fire) begin
          tx_valid_q <= 1'b0;
        end
      end
    end
  end

  wire [DATA_W-1:0] status_byte = {powerup_flag_q, starting_up_i,
                                   5'b00000, low_vref_flag_q};
  wire [DATA_W-1:0] part_byte = {5'b00000, MODEL_CODE_DEFAULT};
  wire [DATA_W-1:0] tx_sel =
    !in_map ? 8'h00 :
    (addr_q == PART_CODE_REG_ADDR) ? part_byte :
    (addr_q == FLAG_REPORT_ADDR) ? status_byte : store_rd;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_byte_o <= 8'h00;
    end else if (clk_en_i && rd_pending_q) begin
      tx_byte_o <= tx_sel;
    end
  end

  assign tx_valid_o = tx_valid_q;
  assign busy_o = (state_q != CMD_IDLE);

  // ************
  // status flags
  // ************
  assign vref_monitor_enable_o =
    regs[VSOURCE_SELECT_ADDR*DATA_W + VREF_MONITOR_ENABLE_BIT];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      powerup_flag_q <= 1'b1;
      low_vref_flag_q <= 1'b0;
    end else if (clk_en_i) begin
      if (status_write && !rx_byte_i[POWERUP_FLAG_BIT]) begin
        powerup_flag_q <= 1'b0;
      end
      low_vref_flag_q <= vref_monitor_enable_o &&
                         vref_below_limit_i;
    end
  end

  // ************
  // conversion restart and trims
  // ************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      restart_q <= 1'b0;
    end else if (clk_en_i) begin
      restart_q <= restart_hit && converting_i;
    end
  end

  assign restart_conv_o = restart_q;
  assign offset_trim_value_o = {regs[OFFSET_TRIM_HIGH_ADDR*DATA_W +: DATA_W],
    regs[OFFSET_TRIM_LOW_ADDR*DATA_W +: DATA_W]};
  assign scale_trim_value_o = {regs[SCALE_TRIM_HIGH_ADDR*DATA_W +: DATA_W],
    regs[SCALE_TRIM_LOW_ADDR*DATA_W +: DATA_W]};
  assign config_bytes_o = regs;

  // ************
  // checks
  // ************
  chk_restart_cause: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && restart_hit && converting_i |=> restart_conv_o)
    else $error("restart missing after restart write");
  chk_restart_only: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    restart_conv_o && $past(clk_en_i) |-> $past(restart_hit && converting_i))
    else $error("restart without cause");
  chk_powerup_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $fell(powerup_flag_q) |-> $past(status_write))
    else $error("power-up flag cleared without status write");
  chk_powerup_reset: assert property (
    @(posedge clk_i)
    $past(sys_rst_i) && !sys_rst_i |-> powerup_flag_q)
    else $error("power-up flag not one after reset");
  chk_vref_gate: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    low_vref_flag_q |-> $past(vref_monitor_enable_o))
    else $error("low reference flag while monitor off");
  chk_lowvref_set: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && vref_monitor_enable_o && vref_below_limit_i
    |=> low_vref_flag_q)
    else $error("low reference flag missing");
  chk_part_code: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(tx_valid_o) && addr_q == PART_CODE_REG_ADDR && in_map
    |-> tx_byte_o[2:0] == MODEL_CODE_DEFAULT)
    else $error("model code wrong");
  chk_startup_bit: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(tx_valid_o) && addr_q == FLAG_REPORT_ADDR && in_map
    |-> tx_byte_o[STARTUP_BIT] == $past(starting_up_i))
    else $error("startup bit not mirrored");
  chk_past_end: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(tx_valid_o) && addr_q > LAST_ADDR |-> tx_byte_o == 8'h00)
    else $error("read past end not zero");
  chk_drop_past_end: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    state_q == CMD_WRITE && rx_take && addr_q > LAST_ADDR |=> $stable(regs))
    else $error("write past end changed a register");
  chk_tx_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_valid_o && !tx_ready_i && frame_active_i && clk_en_i
    |=> tx_valid_o && $stable(tx_byte_o))
    else $error("read byte dropped before handshake");
  chk_trim_pair: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(data_write) && $past(addr_q) == OFFSET_TRIM_LOW_ADDR
    |-> offset_trim_value_o[7:0] == $past(rx_byte_i))
    else $error("trim low byte not applied");
  cov_block_write: cover property (@(posedge clk_i)
    data_write ##1 data_write);
  cov_read_out: cover property (@(posedge clk_i) tx_fire);
  cov_restart: cover property (@(posedge clk_i) restart_conv_o);
  cov_flag_clear: cover property (@(posedge clk_i) $fell(powerup_flag_q));
  cov_read_wait: cover property (@(posedge clk_i) tx_valid_o && !tx_ready_i);
endmodule : adc_config_register_bank
`default_nettype wire

/* src/reg_store.sv */
// byte store for the bank: one flop byte per address, registered read
// assumes write and read addresses are already range checked
`timescale 1ns/1ps
`default_nettype none
module reg_store
  import regbank_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [regbank_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [regbank_pkg::DATA_W-1:0] wr_data_i,
  // read side
  input wire logic [regbank_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [regbank_pkg::DATA_W-1:0] rd_data_o,
  // flat view of all bytes
  output logic [8*18-1:0] all_regs_o
);
  logic [8*18-1:0] regs_q;
  logic [DATA_W-1:0] rd_sel;
  logic rd_in_map;

  assign rd_in_map = (rd_addr_i <= LAST_ADDR);
  assign rd_sel = rd_in_map ? regs_q[rd_addr_i*DATA_W +: DATA_W] : 8'h00;
  assign all_regs_o = regs_q;

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_byte
      logic hit;
      logic [7:0] msk;
      assign hit = wr_en_i && (wr_addr_i == ADDR_W'(g));
      assign msk = WRITE_MASKS[g*8 +: 8];
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          regs_q[g*8 +: 8] <= RESET_VALUES[g*8 +: 8];
        end else if (clk_en_i && hit) begin
          regs_q[g*8 +: 8] <= (wr_data_i & msk) |
                              (regs_q[g*8 +: 8] & ~msk);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (clk_en_i) begin
      rd_data_o <= rd_sel;
    end
  end
endmodule : reg_store
`default_nettype wire
